// [hw/colorbar_pattern_generator.sv]
// Colour-bar pattern generator top with AXI4-Lite registers and framed pixel link.
//
// Local design decisions: the address map and the AXI4-Lite slave port.
module colorbar_pattern_generator (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] pix_data,
    output logic frame_start_low,
    output logic payload_first_low,
    output logic payload_last_low,
    output logic frame_end_low,
    output logic source_ready_low,
    input wire logic dest_ready_low
);
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic aw_got;
        logic w_got;
        logic [7:0] waddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [31:0] ctrl;
        logic [5:0][31:0] pat;
        logic [2:0][19:0][1:0] ram;
        logic [2:0] pend;
        cbar_pkg::upd_state_t ust;
        logic [1:0] ucol;
        logic [4:0] ucnt;
        logic [9:0] col;
        logic [8:0] row;
        logic dir;
        logic [3:0] lfsr;
        logic gap;
    } gen_state_t;

    gen_state_t st_ff;
    gen_state_t nxt_st;
    pix_stream_if gen_s ();
    logic [4:0] gen_bar;
    logic [4:0] gen_step;
    logic [2:0][1:0] gen_sel;
    logic [2:0][7:0] gen_byte;
    logic [3:0] throttle_length_setting;
    logic throttle_length_on;
    logic throttle_ok;
    logic upd_busy;
    logic gen_push;
    logic first_word;
    logic last_word;
    logic buf_valid;
    logic [35:0] buf_data;

    // Merges a write into an old register value under the byte strobes.
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                                input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
            begin
                res[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return res;
    endfunction

    // True for an aligned address inside the six pattern registers.
    function automatic logic is_pat(input logic [7:0] a);
        return (a >= cbar_pkg::OFF_PAT_FIRST) && (a <= cbar_pkg::OFF_PAT_LAST) && (a[1:0] == 2'h0);
    endfunction

    // Bar index and gradient step come straight from the column counter.
    assign gen_bar = st_ff.col[9:5]; // RULE10
    assign gen_step = st_ff.dir ? ~st_ff.col[4:0] : st_ff.col[4:0]; // RULE7 RULE6 RULE5

    // One shifter per colour; code zero means the colour is off.
    for (genvar c = 0; c < 3; c++)
    begin : g_colour
        logic [7:0] shifted;
        assign gen_sel[c] = st_ff.ram[c][gen_bar]; // RULE9
        assign shifted = {3'h0, gen_step} << gen_sel[c]; // RULE8
        assign gen_byte[c] = (gen_sel[c] == 2'h0) ? 8'h00 : shifted; // RULE14
    end

    // Throttle: the length mode wins if software enables both, which it should not.
    assign throttle_length_on = st_ff.ctrl[cbar_pkg::CTRL_LEN_ON_BIT];
    assign throttle_length_setting = st_ff.ctrl[cbar_pkg::CTRL_LEN_LSB +: 4];
    always_comb
    begin
        if (throttle_length_on)
        begin
            throttle_ok = st_ff.lfsr < throttle_length_setting; // RULE16
        end
        else if (st_ff.ctrl[cbar_pkg::CTRL_GAP_ON_BIT])
        begin
            throttle_ok = st_ff.gap; // RULE13
        end
        else
        begin
            throttle_ok = 1'b1;
        end
    end

    // Offer a word only while running, not reloading and not throttled.
    assign upd_busy = (st_ff.ust == cbar_pkg::UPD_RUN);
    assign first_word = (st_ff.col == 10'h000);
    assign last_word = (st_ff.col == cbar_pkg::COL_LAST);
    assign gen_s.valid = st_ff.ctrl[cbar_pkg::CTRL_RUN_BIT] && !upd_busy && throttle_ok; // RULE15
    assign gen_s.data = {first_word, first_word, last_word, last_word,
                         cbar_pkg::PIXEL_TAG, gen_byte[0], gen_byte[1], gen_byte[2]}; // RULE2 RULE18 RULE3
    assign gen_push = gen_s.valid && gen_s.ready;

    // Next-state logic for the bus slave, pattern reload and pixel counters.
    always_comb
    begin
        nxt_st = st_ff;
        if (throttle_length_on)
        begin
            nxt_st.lfsr = {st_ff.lfsr[2:0], st_ff.lfsr[3] ^ st_ff.lfsr[2]};
        end
        nxt_st.gap = !st_ff.gap;
        if (gen_push)
        begin
            if (last_word)
            begin
                nxt_st.col = 10'h000; // RULE11
                nxt_st.row = (st_ff.row == cbar_pkg::ROW_LAST) ? 9'h000 : st_ff.row + 9'h001; // RULE4 RULE1
                if ((st_ff.row == cbar_pkg::ROW_HALF_LAST) || (st_ff.row == cbar_pkg::ROW_LAST))
                begin
                    nxt_st.dir = !st_ff.dir; // RULE12
                end
            end
            else
            begin
                nxt_st.col = st_ff.col + 10'h001;
            end
        end
        // Reload sequencer walks one colour's twenty entries, lowest colour first.
        case (st_ff.ust)
            cbar_pkg::UPD_IDLE:
            begin
                if (st_ff.pend != 3'h0)
                begin
                    nxt_st.ucol = st_ff.pend[0] ? 2'h0 : (st_ff.pend[1] ? 2'h1 : 2'h2);
                    nxt_st.pend[nxt_st.ucol] = 1'b0;
                    nxt_st.ucnt = 5'h00;
                    nxt_st.ust = cbar_pkg::UPD_RUN;
                end
            end
            cbar_pkg::UPD_RUN:
            begin
                nxt_st.ram[st_ff.ucol][st_ff.ucnt] = {st_ff.pat[{st_ff.ucol, 1'b0}][5'h1f - st_ff.ucnt],
                                                      st_ff.pat[{st_ff.ucol, 1'b1}][5'h1f - st_ff.ucnt]}; // RULE15
                if (st_ff.ucnt == cbar_pkg::UPD_LAST)
                begin
                    nxt_st.ust = cbar_pkg::UPD_IDLE;
                end
                else
                begin
                    nxt_st.ucnt = st_ff.ucnt + 5'h01;
                end
            end
            default:
            begin
                nxt_st.ust = cbar_pkg::UPD_IDLE;
            end
        endcase
        // Write channel: address and data are taken in either order, then applied together.
        if (s_axi_awvalid && st_ff.awready)
        begin
            nxt_st.aw_got = 1'b1;
            nxt_st.waddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_ff.wready)
        begin
            nxt_st.w_got = 1'b1;
            nxt_st.wdata = s_axi_wdata;
            nxt_st.wstrb = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready)
        begin
            nxt_st.bvalid = 1'b0;
        end
        if (st_ff.aw_got && st_ff.w_got && !st_ff.bvalid)
        begin
            nxt_st.aw_got = 1'b0;
            nxt_st.w_got = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp = cbar_pkg::RESP_OKAY;
            if (st_ff.waddr == cbar_pkg::OFF_CTRL)
            begin
                nxt_st.ctrl = merge_bytes(st_ff.ctrl, st_ff.wdata, st_ff.wstrb);
            end
            else if (is_pat(st_ff.waddr))
            begin
                // A write arriving while its colour is taken still leaves the pending bit set.
                nxt_st.pat[3'((st_ff.waddr - cbar_pkg::OFF_PAT_FIRST) >> 2)] =
                    merge_bytes(st_ff.pat[3'((st_ff.waddr - cbar_pkg::OFF_PAT_FIRST) >> 2)],
                                st_ff.wdata, st_ff.wstrb) & cbar_pkg::PAT_MASK;
                nxt_st.pend[2'((st_ff.waddr - cbar_pkg::OFF_PAT_FIRST) >> 3)] = 1'b1; // RULE15
            end
            else if (st_ff.waddr != cbar_pkg::OFF_STATUS)
            begin
                nxt_st.bresp = cbar_pkg::RESP_SLVERR;
            end
        end
        nxt_st.awready = !nxt_st.aw_got && !nxt_st.bvalid;
        nxt_st.wready = !nxt_st.w_got && !nxt_st.bvalid;
        // Read channel: one read at a time, answered on the cycle after the address is taken.
        if (s_axi_rvalid && s_axi_rready)
        begin
            nxt_st.rvalid = 1'b0;
            nxt_st.arready = 1'b1;
        end
        if (s_axi_arvalid && st_ff.arready)
        begin
            nxt_st.arready = 1'b0;
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp = cbar_pkg::RESP_OKAY;
            nxt_st.rdata = 32'h0000_0000;
            if (s_axi_araddr == cbar_pkg::OFF_CTRL)
            begin
                nxt_st.rdata = st_ff.ctrl;
            end
            else if (s_axi_araddr == cbar_pkg::OFF_STATUS)
            begin
                nxt_st.rdata[cbar_pkg::STAT_BUSY_BIT] = upd_busy;
                nxt_st.rdata[cbar_pkg::STAT_DIR_BIT] = st_ff.dir;
                nxt_st.rdata[cbar_pkg::STAT_PEND_LSB +: 3] = st_ff.pend;
                nxt_st.rdata[cbar_pkg::STAT_ROW_LSB +: 9] = st_ff.row;
            end
            else if (is_pat(s_axi_araddr))
            begin
                nxt_st.rdata = st_ff.pat[3'((s_axi_araddr - cbar_pkg::OFF_PAT_FIRST) >> 2)];
            end
            else
            begin
                nxt_st.rresp = cbar_pkg::RESP_SLVERR;
            end
        end
    end

    // State register; the bar RAM resets to the same contents as the pattern registers.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_ff <= '0;
            st_ff.awready <= 1'b1;
            st_ff.wready <= 1'b1;
            st_ff.arready <= 1'b1;
            st_ff.ctrl <= cbar_pkg::CTRL_RESET;
            st_ff.lfsr <= cbar_pkg::LFSR_SEED;
            st_ff.ust <= cbar_pkg::UPD_IDLE;
            for (int r = 0; r < 6; r++)
            begin
                st_ff.pat[r] <= cbar_pkg::PAT_RESET[r];
            end
            for (int c = 0; c < 3; c++)
            begin
                for (int n = 0; n < 20; n++)
                begin
                    st_ff.ram[c][n] <= {cbar_pkg::PAT_RESET[2*c][31-n], cbar_pkg::PAT_RESET[2*c+1][31-n]};
                end
            end
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // The buffer keeps a stalled word so a link hold-off loses nothing.
    two_entry_buffer u_buf (
        .aclk(aclk),
        .aresetn(aresetn),
        .in_s(gen_s),
        .out_valid(buf_valid),
        .out_ready(!dest_ready_low), // RULE17
        .out_data(buf_data)
    );

    assign s_axi_awready = st_ff.awready;
    assign s_axi_wready = st_ff.wready;
    assign s_axi_bvalid = st_ff.bvalid;
    assign s_axi_bresp = st_ff.bresp;
    assign s_axi_arready = st_ff.arready;
    assign s_axi_rvalid = st_ff.rvalid;
    assign s_axi_rresp = st_ff.rresp;
    assign s_axi_rdata = st_ff.rdata;
    assign pix_data = buf_data[31:0];
    assign frame_start_low = !buf_data[cbar_pkg::FLAG_SOF_BIT];
    assign payload_first_low = !buf_data[cbar_pkg::FLAG_SOP_BIT];
    assign payload_last_low = !buf_data[cbar_pkg::FLAG_EOP_BIT];
    assign frame_end_low = !buf_data[cbar_pkg::FLAG_EOF_BIT];
    assign source_ready_low = !buf_valid;

    // Link-side checks.
    tag_byte_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE2
        !source_ready_low |-> pix_data[31:24] == 8'haa) else $error("pixel tag byte wrong");
    flag_pair_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE18
        !source_ready_low |-> (frame_start_low == payload_first_low) && (frame_end_low == payload_last_low))
        else $error("frame and payload flags disagree");
    link_hold_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE17
        (!source_ready_low && dest_ready_low) |=> !source_ready_low && $stable(pix_data) && $stable(payload_last_low))
        else $error("word changed while stalled");
    // Counter, pattern and throttle checks.
    count_range_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE1
        st_ff.col <= 10'h27f && st_ff.row <= 9'h1df) else $error("pixel counters out of range");
    line_wrap_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE4
        (gen_push && st_ff.col == 10'h27f) |=> st_ff.col == 10'h000 && st_ff.row != $past(st_ff.row))
        else $error("line end did not advance row");
    half_dir_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE12
        st_ff.dir == (st_ff.row >= 9'h0f0)) else $error("gradient direction wrong for half");
    step_walk_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE7
        (gen_push && !st_ff.dir && st_ff.col[4:0] != 5'h1f) |=> gen_step == $past(gen_step) + 5'h01)
        else $error("step did not count up");
    full_bright_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE9
        (gen_push && gen_sel[1] == 2'h3 && gen_step == 5'h1f) |-> gen_byte[1] == 8'hf8)
        else $error("full brightness byte wrong");
    bar_limit_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE11
        gen_bar < 5'h14) else $error("bar index beyond twenty");
    reload_block_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE15
        $rose(upd_busy) |-> (upd_busy && !gen_push)[*8] ##13 !upd_busy) else $error("reload length or block wrong");
    zero_len_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE16
        (throttle_length_on && throttle_length_setting == 4'h0) |-> !gen_push) else $error("zero length let data out");
endmodule

// [hw/cbar_pkg.sv]
// Package with register map, field positions, reset values and counts for the colour-bar generator.
// Operation
// (RULE1) Image is 640 pixels by 480 lines.
// (RULE2) Pixel word is 0xAA, red, green, blue.
// (RULE3) One link frame per video line.
// (RULE4) 480 frames per field, then repeat.
// (RULE5) Lower half mirrors upper half per bar.
// (RULE6) Each bar spans 32 pixels, one step each.
// (RULE7) 5-bit step counts up or down by half.
// (RULE8) Per-colour shifter places step in byte.
// (RULE9) Two-bit selections give black/25/50/100 percent.
// (RULE10) Column upper five bits address the bar.
// (RULE11) Twenty bars make one line payload.
// (RULE12) Direction toggles after every 240 frames.
// (RULE13) Software inserts fixed or varying idle clocks.
// (RULE14) Zero selection forces byte to zero.
// (RULE15) Pattern write reloads RAM, blocks streaming.
// (RULE16) Length throttle uses LFSR below setting.
// (RULE17) Word moves only when both readies low.
// (RULE18) Start flags first word, end flags last.
package cbar_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned FRAME_W = 36;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_PAT_FIRST = 8'h08;
    localparam logic [7:0] OFF_PAT_LAST = 8'h1c;
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_LEN_ON_BIT = 1;
    localparam int CTRL_GAP_ON_BIT = 2;
    localparam int CTRL_LEN_LSB = 4;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DIR_BIT = 1;
    localparam int STAT_PEND_LSB = 4;
    localparam int STAT_ROW_LSB = 16;
    localparam int FLAG_SOF_BIT = 35;
    localparam int FLAG_SOP_BIT = 34;
    localparam int FLAG_EOP_BIT = 33;
    localparam int FLAG_EOF_BIT = 32;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] PAT_MASK = 32'hffff_f000;
    // Order: red high, red low, green high, green low, blue high, blue low; bar 0 at bit 31.
    localparam logic [31:0] PAT_RESET [0:5] = '{32'hf0f0_f000, 32'hcccc_c000, 32'hff00_f000,
                                                 32'haaaa_a000, 32'h0ff0_f000, 32'h5555_5000};
    localparam logic [7:0] PIXEL_TAG = 8'haa;
    localparam logic [9:0] COL_LAST = 10'h27f;
    localparam logic [8:0] ROW_LAST = 9'h1df;
    localparam logic [8:0] ROW_HALF_LAST = 9'h0ef;
    localparam logic [4:0] STEP_LAST = 5'h1f;
    localparam logic [4:0] BAR_COUNT = 5'h14;
    localparam logic [4:0] UPD_LAST = 5'h13;
    localparam logic [3:0] LFSR_SEED = 4'h1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [0:0] {UPD_IDLE = 1'b0, UPD_RUN = 1'b1} upd_state_t;
endpackage

// [hw/pix_stream_if.sv]
// Interface carrying framed pixel words from the generator into the output buffer.
interface pix_stream_if;
    logic valid;
    logic ready;
    logic [35:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// [hw/two_entry_buffer.sv]
// Two-entry buffer between the pixel source and the link pins.
module two_entry_buffer (
    input wire logic aclk,
    input wire logic aresetn,
    pix_stream_if.snk in_s,
    output logic out_valid,
    input wire logic out_ready,
    output logic [35:0] out_data
);
    typedef struct packed {
        logic out_vld;
        logic skd_vld;
        logic in_rdy;
        logic [35:0] out_dat;
        logic [35:0] skd_dat;
    } buf_state_t;

    buf_state_t st_ff;
    buf_state_t nxt_st;
    logic take_in;
    logic drain;

    // The second entry catches the word taken while the output stalls, so ready may lag by one cycle.
    assign take_in = in_s.valid && st_ff.in_rdy;
    assign drain = out_ready || !st_ff.out_vld;

    always_comb
    begin
        nxt_st = st_ff;
        if (drain)
        begin
            if (st_ff.skd_vld)
            begin
                nxt_st.out_vld = 1'b1;
                nxt_st.out_dat = st_ff.skd_dat;
                nxt_st.skd_vld = 1'b0;
            end
            else
            begin
                nxt_st.out_vld = take_in;
                if (take_in)
                begin
                    nxt_st.out_dat = in_s.data;
                end
            end
        end
        else if (take_in)
        begin
            nxt_st.skd_vld = 1'b1;
            nxt_st.skd_dat = in_s.data;
        end
        nxt_st.in_rdy = !nxt_st.skd_vld;
    end

    // Output word and its valid stay put until the link takes them.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_ff <= '0;
            st_ff.in_rdy <= 1'b1;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign in_s.ready = st_ff.in_rdy;
    assign out_valid = st_ff.out_vld;
    assign out_data = st_ff.out_dat;
endmodule

// [verification/dma_rx_model.sv]
// Behavioural receive channel of a DMA engine taking framed pixel words.
module dma_rx_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic stall_on,
    output logic dest_ready_low
);
    timeunit 1ns;
    timeprecision 1ns;
    int seed = 11;
    // The receiver may stall in any cycle; random stalls exercise the held-word path of the source.
    always @(posedge aclk)
    begin
        if (!aresetn)
            dest_ready_low <= 1'b1;
        else
            dest_ready_low <= stall_on ? (($random(seed) & 3) == 0) : 1'b0;
    end
endmodule

// [verification/test_colorbar_pattern_generator.sv]
// Self-checking testbench for the colour-bar generator, its registers and its pixel link.
module test_colorbar_pattern_generator;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, stall_on;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [2:0] s_axi_awprot, s_axi_arprot;
    logic [3:0] s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata, pix_data, rd;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic frame_start_low, payload_first_low, payload_last_low, frame_end_low, source_ready_low, dest_ready_low;
    logic [31:0] pat [0:5];
    logic [35:0] exp_q [$];
    int n_errors = 0;
    int n_checks = 0;
    int n_words = 0;
    int next_row = 0;
    int seed = 11;
    int n_back = 0;
    logic moved = 1'b0;
    logic moved_prev = 1'b0;
    logic gap_watch = 1'b0;
    time t_mark;

    colorbar_pattern_generator dut (.*);
    dma_rx_model partner (.aclk(aclk), .aresetn(aresetn), .stall_on(stall_on), .dest_ready_low(dest_ready_low));

    // Free-running bus clock.
    initial
    begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    task automatic chk(input logic [35:0] got, input logic [35:0] exp, input string what);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Address and data are offered together; each is dropped once taken, then the response is awaited.
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1)
                s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        resp = s_axi_bresp;
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1)
                s_axi_arvalid <= 1'b0;
        end
        while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        resp = s_axi_rresp;
    endtask

    // Expected word with its four active-low flags on top, worked out from position and patterns.
    function automatic logic [35:0] exp_word(int row, int col);
        logic [4:0] step;
        logic [7:0] b [0:2];
        logic [1:0] sel;
        int bar;
        step = (row < 240) ? col[4:0] : 5'h1f - col[4:0];
        bar = col / 32;
        for (int k = 0; k < 3; k++)
        begin
            sel = {pat[2 * k][31 - bar], pat[2 * k + 1][31 - bar]};
            b[k] = (sel == 2'h0) ? 8'h00 : ({3'h0, step} << sel);
        end
        return {col != 0, col != 0, col != 639, col != 639, cbar_pkg::PIXEL_TAG, b[0], b[1], b[2]};
    endfunction

    // Lines are noted ahead, so a word fetched early by the buffer still finds its note.
    task automatic push_lines(input int n);
        for (int r = 0; r < n; r++)
        begin
            for (int c = 0; c < 640; c++)
                exp_q.push_back(exp_word(next_row, c));
            next_row++;
        end
    endtask

    task automatic wait_q(input int left, input string name);
        int n;
        n = 0;
        while (exp_q.size() > left && n < 20000)
        begin
            @(posedge aclk);
            n++;
        end
        chk(36'(exp_q.size() <= left), 36'h1, "stream stalled");
        $display("test %s done", name);
    endtask

    // Every transferred word is matched against the oldest note.
    always @(posedge aclk)
    begin
        moved = aresetn === 1'b1 && source_ready_low === 1'b0 && dest_ready_low === 1'b0;
        if (gap_watch && moved && moved_prev)
            n_back++;
        moved_prev = moved;
        if (moved)
        begin
            n_words++;
            if (exp_q.size() == 0)
                chk(36'h0, 36'h1, "unexpected word");
            else
                chk({frame_start_low, payload_first_low, payload_last_low, frame_end_low, pix_data},
                    exp_q.pop_front(), "pixel");
        end
    end

    // A hang is cut short well beyond the expected run time.
    initial
    begin
        repeat (40000) @(posedge aclk);
        chk(36'h0, 36'h1, "watchdog");
        tally_and_finish();
    end

    initial
    begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = 54'h0;
        s_axi_wstrb = 4'hf;
        stall_on = 1'b1;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        axi_read(cbar_pkg::OFF_CTRL, rd, rs);
        chk({2'h0, rs, rd}, {2'h0, cbar_pkg::RESP_OKAY, cbar_pkg::CTRL_RESET}, "ctrl reset");
        for (int i = 0; i < 6; i++)
        begin
            axi_read(cbar_pkg::OFF_PAT_FIRST + 8'(i * 4), rd, rs);
            chk({2'h0, rs, rd}, {2'h0, cbar_pkg::RESP_OKAY, cbar_pkg::PAT_RESET[i] & cbar_pkg::PAT_MASK}, "pat reset");
        end
        axi_read(8'h40, rd, rs);
        chk({2'h0, rs, rd}, {2'h0, cbar_pkg::RESP_SLVERR, 32'h0}, "unmapped read");
        axi_write(8'h40, 32'hffff_ffff, rs);
        chk({34'h0, rs}, {34'h0, cbar_pkg::RESP_SLVERR}, "unmapped write");
        axi_write(cbar_pkg::OFF_STATUS, 32'hffff_ffff, rs);
        chk({34'h0, rs}, {34'h0, cbar_pkg::RESP_OKAY}, "status write");
        axi_read(cbar_pkg::OFF_STATUS, rd, rs);
        chk({2'h0, rs, rd}, 36'h0, "status idle");
        // Only byte one is enabled, so the run and throttle bits stay clear.
        s_axi_wstrb <= 4'h2;
        axi_write(cbar_pkg::OFF_CTRL, 32'hffff_ffff, rs);
        s_axi_wstrb <= 4'hf;
        axi_read(cbar_pkg::OFF_CTRL, rd, rs);
        chk({2'h0, rs, rd}, 36'h0_0000_ff00, "strobed ctrl");
        $display("test registers done");
        // New random patterns; each write starts a reload that shows as busy or pending.
        for (int i = 0; i < 6; i++)
        begin
            pat[i] = $random(seed) & cbar_pkg::PAT_MASK;
            axi_write(cbar_pkg::OFF_PAT_FIRST + 8'(i * 4), pat[i], rs);
            axi_read(cbar_pkg::OFF_STATUS, rd, rs);
            chk(36'(rd[6:0] != 7'h0), 36'h1, "reload busy");
            for (int n = 0; n < 100 && rd[6:0] !== 7'h0; n++)
                axi_read(cbar_pkg::OFF_STATUS, rd, rs);
            axi_read(cbar_pkg::OFF_PAT_FIRST + 8'(i * 4), rd, rs);
            chk({4'h0, rd}, {4'h0, pat[i]}, "pat readback");
        end
        $display("test patterns done");
        push_lines(4);
        // Length throttle with a zero setting must send nothing.
        axi_write(cbar_pkg::OFF_CTRL, 32'h0000_0003, rs);
        repeat (100) @(posedge aclk);
        chk(36'(n_words), 36'h0, "length zero");
        $display("test length zero done");
        axi_write(cbar_pkg::OFF_CTRL, 32'h0000_0001, rs);
        wait_q(1280, "free run");
        axi_write(cbar_pkg::OFF_CTRL, 32'h0000_0043, rs);
        t_mark = $time;
        wait_q(640, "length four");
        // Three of every fifteen generator values pass a setting of four, so 640 words need over 3000 cycles.
        chk(36'(($time - t_mark) >= 300000), 36'h1, "length rate");
        stall_on <= 1'b0;
        axi_write(cbar_pkg::OFF_CTRL, 32'h0000_0005, rs);
        repeat (4) @(posedge aclk);
        gap_watch <= 1'b1;
        wait_q(0, "fixed gap");
        chk(36'(n_back), 36'h0, "gap back to back");
        tally_and_finish();
    end
endmodule
